// ---- hdl/mpf_pkg.sv ----
// package for the power/flow control and bus performance counter bank
// =====================================
// How it works
// - eeprom power-mgmt bit zero clears capability pointer
// - power-mgmt bit mirrored to new-capabilities flag
// - power mode wakes on pattern, unicast, multicast
// - writing wake-lan bit one enters sleep
// - sleep held until wake, clear or reset
// - wake-lan mode accepts pattern wake frame only
// - pointer reset bit resets wake pattern pointer
// - pause default from auto-negotiation, software may overwrite
// - pause bit enables or disables pause flow control
// - threshold enable zero forces 64-byte threshold
// - underrun recover bit enables automatic recovery
// - clock count counts master read clocks
// - clock count accumulates between counter reads
// - dword count accumulates between counter reads
package mpf_pkg;
  // =====================================
  // register map
  localparam logic [3:0] MPF_OFF_CTRL = 4'h0;
  localparam logic [3:0] MPF_OFF_PERF = 4'h4;
  localparam logic [3:0] MPF_OFF_STAT = 4'h8;
  localparam logic [3:0] MPF_OFF_MASK = 4'hc;
  // =====================================
  // control field positions
  localparam int MPF_B_PM = 19;
  localparam int MPF_B_WOL = 18;
  localparam int MPF_B_RWP = 6;
  localparam int MPF_B_PAUSE = 5;
  localparam int MPF_B_RTE = 4;
  localparam int MPF_B_DRT_LO = 2;
  localparam int MPF_B_SOFT_IRQ_REQUEST = 1;
  localparam int MPF_B_AUTO_TX_UNDERRUN_RECOVER = 0;
  localparam int MPF_B_NC = 20;
  localparam logic [1:0] MPF_DRT_RST = 2'h1;
  localparam logic [7:0] MPF_CAP_PTR_PM = 8'h50;
  // =====================================
  // status bits
  localparam int MPF_S_WAKE = 0;
  localparam int MPF_S_CLK_OVF = 1;
  localparam int MPF_S_DW_OVF = 2;
  localparam int MPF_NSTAT = 3;

  typedef enum logic [1:0] {
    MPF_THR_32 = 2'b00,
    MPF_THR_64 = 2'b01,
    MPF_THR_SF = 2'b10,
    MPF_THR_RSV = 2'b11
  } mpf_thr_type;

  typedef enum logic [1:0] {
    MPF_AWAKE = 2'b00,
    MPF_SLEEP = 2'b01
  } mpf_pwr_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mpf_bus_type;

  typedef struct packed {
    logic magic;
    logic unicast;
    logic multicast;
  } mpf_wake_type;
endpackage : mpf_pkg

// ---- hdl/mpf_ctrl.sv ----
// power/flow control register and bus-master performance counter
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module mpf_ctrl
  import mpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire mpf_bus_type bus,
  output logic [31:0] rdata,
  input wire logic eeprom_load,
  input wire logic eeprom_pm,
  input wire logic eeprom_wol,
  input wire logic aneg_done,
  input wire logic aneg_pause,
  input wire mpf_wake_type wake_frame,
  input wire logic mst_rd_busy,
  input wire logic mst_dword,
  output logic [7:0] cap_ptr,
  output logic new_caps,
  output logic sleep_state,
  output logic wake_event,
  output logic pattern_ptr_reset,
  output logic pause_enable,
  output mpf_thr_type rx_threshold,
  output logic auto_tx_underrun_recover,
  output logic soft_irq_request,
  output logic irq
);
  // =====================================
  // control register state
  logic pwr_mgmt_cap_enable_r;
  logic wake_lan_sleep_enable_r;
  logic wake_pattern_ptr_reset_r;
  logic pause_r;
  logic pause_sw_r;
  logic rx_threshold_enable_r;
  logic [1:0] rx_drain_threshold_r;
  logic soft_irq_r;
  logic auto_tx_underrun_recover_r;
  mpf_pwr_type pwr_r;
  mpf_pwr_type pwr_nxt;
  logic [15:0] read_clock_count_r;
  logic [7:0] dword_transfer_count_r;
  logic [MPF_NSTAT-1:0] stat_r;
  logic [MPF_NSTAT-1:0] mask_r;
  logic [31:0] rdata_r;
  logic [7:0] cap_ptr_r;
  logic new_caps_r;
  logic wake_r;
  mpf_thr_type thr_r;
  logic irq_r;
  logic sleep_r;

  // =====================================
  // decode
  wire wr_ctrl = bus.wr && bus.addr == MPF_OFF_CTRL;
  wire wr_mask = bus.wr && bus.addr == MPF_OFF_MASK;
  wire rd_perf = bus.rd && bus.addr == MPF_OFF_PERF;
  wire rd_stat = bus.rd && bus.addr == MPF_OFF_STAT;

  // in sleep only the pattern frame counts; awake, all three do when power management is enabled
  wire wake_hit = (pwr_r == MPF_SLEEP) ? wake_frame.magic
                : pwr_mgmt_cap_enable_r && (wake_frame.magic || wake_frame.unicast
                  || wake_frame.multicast);

  wire wol_next = wr_ctrl ? bus.wdata[MPF_B_WOL] : wake_lan_sleep_enable_r;

  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      MPF_AWAKE: if (wr_ctrl && bus.wdata[MPF_B_WOL]) pwr_nxt = MPF_SLEEP;
      MPF_SLEEP: if (wake_hit || !wol_next) pwr_nxt = MPF_AWAKE;
      default: pwr_nxt = MPF_AWAKE;
    endcase
  end

  wire [31:0] ctrl_view = {12'h000, pwr_mgmt_cap_enable_r, wake_lan_sleep_enable_r, 11'h000,
    wake_pattern_ptr_reset_r, pause_r, rx_threshold_enable_r, rx_drain_threshold_r,
    soft_irq_r, auto_tx_underrun_recover_r};
  wire [31:0] perf_view = {read_clock_count_r, 8'h00, dword_transfer_count_r};

  // fixed 64 bytes unless threshold selection is enabled
  wire mpf_thr_type thr_sel = rx_threshold_enable_r ? mpf_thr_type'(rx_drain_threshold_r)
                                                    : MPF_THR_64;

  wire clk_ovf = mst_rd_busy && &read_clock_count_r && !rd_perf;
  wire dw_ovf = mst_dword && &dword_transfer_count_r && !rd_perf;
  wire [MPF_NSTAT-1:0] ev = {dw_ovf, clk_ovf, wake_hit && pwr_r == MPF_SLEEP};

  wire [31:0] rd_mux = (bus.addr == MPF_OFF_CTRL) ? ctrl_view
                     : (bus.addr == MPF_OFF_PERF) ? perf_view
                     : (bus.addr == MPF_OFF_STAT) ? {29'h0, stat_r}
                     : (bus.addr == MPF_OFF_MASK) ? {29'h0, mask_r}
                     : 32'h0;

  // =====================================
  // control register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_mgmt_cap_enable_r <= 1'b0;
      wake_lan_sleep_enable_r <= 1'b0;
      wake_pattern_ptr_reset_r <= 1'b0;
      rx_threshold_enable_r <= 1'b0;
      rx_drain_threshold_r <= MPF_DRT_RST;
      soft_irq_r <= 1'b0;
      auto_tx_underrun_recover_r <= 1'b0;
    end else begin
      if (eeprom_load) begin
        pwr_mgmt_cap_enable_r <= eeprom_pm;
      end
      if (wr_ctrl) begin
        wake_lan_sleep_enable_r <= bus.wdata[MPF_B_WOL];
        wake_pattern_ptr_reset_r <= bus.wdata[MPF_B_RWP];
        rx_threshold_enable_r <= bus.wdata[MPF_B_RTE];
        rx_drain_threshold_r <= bus.wdata[MPF_B_DRT_LO +: 2];
        soft_irq_r <= bus.wdata[MPF_B_SOFT_IRQ_REQUEST];
        auto_tx_underrun_recover_r <= bus.wdata[MPF_B_AUTO_TX_UNDERRUN_RECOVER];
      end else if (eeprom_load) begin
        wake_lan_sleep_enable_r <= eeprom_wol;
      end else if (pwr_r == MPF_SLEEP && pwr_nxt == MPF_AWAKE) begin
        wake_lan_sleep_enable_r <= 1'b0;
      end
    end
  end

  // pause follows negotiation until software writes it afterwards
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pause_r <= 1'b0;
      pause_sw_r <= 1'b0;
    end else if (wr_ctrl && aneg_done) begin
      pause_r <= bus.wdata[MPF_B_PAUSE];
      pause_sw_r <= 1'b1;
    end else if (!aneg_done) begin
      pause_r <= aneg_pause;
      pause_sw_r <= 1'b0;
    end else if (!pause_sw_r) begin
      pause_r <= aneg_pause;
    end
  end

  // =====================================
  // performance counters, saturating; overflow flagged in status
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      read_clock_count_r <= 16'h0000;
      dword_transfer_count_r <= 8'h00;
    end else begin
      if (rd_perf) begin
        read_clock_count_r <= {15'h0000, mst_rd_busy};
      end else if (mst_rd_busy && !(&read_clock_count_r)) begin
        read_clock_count_r <= read_clock_count_r + 16'h0001;
      end
      if (rd_perf) begin
        dword_transfer_count_r <= {7'h00, mst_dword};
      end else if (mst_dword && !(&dword_transfer_count_r)) begin
        dword_transfer_count_r <= dword_transfer_count_r + 8'h01;
      end
    end
  end

  // =====================================
  // status, mask, interrupt; a new event wins over the read clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= (rd_stat ? '0 : stat_r) | ev;
      if (wr_mask) mask_r <= bus.wdata[MPF_NSTAT-1:0];
      irq_r <= |(((rd_stat ? '0 : stat_r) | ev) & mask_r) || soft_irq_r;
    end
  end

  // =====================================
  // registered outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r <= MPF_AWAKE;
      rdata_r <= 32'h0;
      cap_ptr_r <= 8'h00;
      new_caps_r <= 1'b0;
      wake_r <= 1'b0;
      thr_r <= MPF_THR_64;
      sleep_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      sleep_r <= (pwr_nxt == MPF_SLEEP);
      rdata_r <= bus.rd ? rd_mux : 32'h0;
      cap_ptr_r <= pwr_mgmt_cap_enable_r ? MPF_CAP_PTR_PM : 8'h00;
      new_caps_r <= pwr_mgmt_cap_enable_r;
      wake_r <= wake_hit;
      thr_r <= thr_sel;
    end
  end

  assign rdata = rdata_r;
  assign cap_ptr = cap_ptr_r;
  assign new_caps = new_caps_r;
  assign sleep_state = sleep_r;
  assign wake_event = wake_r;
  assign pattern_ptr_reset = wake_pattern_ptr_reset_r;
  assign pause_enable = pause_r;
  assign rx_threshold = thr_r;
  assign auto_tx_underrun_recover = auto_tx_underrun_recover_r;
  assign soft_irq_request = soft_irq_r;
  assign irq = irq_r;
endmodule : mpf_ctrl

// ---- bench/mpf_ctrl_asserts.sv ----
// port assertions for the power/flow control bank
`timescale 1ns/100ps
module mpf_ctrl_asserts
  import mpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire mpf_bus_type bus,
  input wire logic [31:0] rdata,
  input wire logic aneg_done,
  input wire logic aneg_pause,
  input wire logic eeprom_load,
  input wire mpf_wake_type wake_frame,
  input wire logic mst_rd_busy,
  input wire logic mst_dword,
  input wire logic [7:0] cap_ptr,
  input wire logic new_caps,
  input wire logic sleep_state,
  input wire logic pause_enable,
  input wire mpf_thr_type rx_threshold,
  input wire logic soft_irq_request,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire ctrl_wr = bus.wr && bus.addr == MPF_OFF_CTRL;
  // quiet read: a count event in the read cycle would land after the clear
  wire perf_rd = bus.rd && bus.addr == MPF_OFF_PERF && !mst_rd_busy && !mst_dword;
  // ====================
  // properties
  cap_ptr_a: assert property (cap_ptr == (new_caps ? MPF_CAP_PTR_PM : 8'h00))
    else $error("cap pointer wrong");
  perf_clr_a: assert property (
    perf_rd ##1 !(mst_rd_busy || mst_dword) ##1 perf_rd |=> rdata == 32'h0)
    else $error("perf counter not cleared");
  thr_sel_a: assert property (
    // threshold output is registered behind the control bits: two cycles
    ctrl_wr |-> ##2 rx_threshold == ($past(bus.wdata[MPF_B_RTE], 2)
      ? $past(bus.wdata[MPF_B_DRT_LO +: 2], 2) : MPF_THR_64))
    else $error("rx threshold wrong");
  soft_bit_a: assert property (ctrl_wr |=> soft_irq_request == $past(bus.wdata[1]))
    else $error("soft irq bit wrong");
  irq_soft_a: assert property (soft_irq_request [*2] |-> irq)
    else $error("irq low with soft request");
  sleep_in_a: assert property (
    ctrl_wr && bus.wdata[MPF_B_WOL] && !wake_frame.magic |-> ##[1:2] sleep_state)
    else $error("sleep not entered");
  sleep_hold_a: assert property (
    (sleep_state && !wake_frame.magic && !ctrl_wr && !eeprom_load) [*2] |=> sleep_state)
    else $error("sleep left without cause");
  pause_fol_a: assert property (
    // sampled reset keeps the release edge out, the flops are still held there
    (arst_n && !aneg_done && $stable(aneg_pause)) [*2] |-> pause_enable == aneg_pause)
    else $error("pause not following negotiation");
endmodule : mpf_ctrl_asserts

bind mpf_ctrl mpf_ctrl_asserts mpf_ctrl_asserts_i (.core_clk, .arst_n, .bus, .rdata,
  .aneg_done, .aneg_pause, .eeprom_load, .wake_frame, .mst_rd_busy, .mst_dword, .cap_ptr,
  .new_caps,
  .sleep_state, .pause_enable, .rx_threshold, .soft_irq_request, .irq);

// ---- bench/tb.sv ----
// self-checking bench for the power/flow control bank
`timescale 1ns/100ps
module tb;
  import mpf_pkg::*;
  logic core_clk = 0, arst_n = 0, eeprom_load = 0, eeprom_pm = 0, eeprom_wol = 0;
  logic aneg_done = 0, aneg_pause = 1, mst_rd_busy = 0, mst_dword = 0;
  logic new_caps, sleep_state, wake_event, pattern_ptr_reset, pause_enable;
  logic auto_tx_underrun_recover, soft_irq_request, irq;
  logic [7:0] cap_ptr;
  logic [31:0] rdata, d, r;
  mpf_bus_type bus = '0;
  mpf_wake_type wake_frame = '0;
  mpf_thr_type rx_threshold;
  int seed = 93, err_total = 0, checked = 0, cyc = 0, n;
  always #5 core_clk = ~core_clk;
  mpf_ctrl mpf_ctrl_i (.*);
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      stop_test();
    end
  end
  // ====================
  // helpers
  task automatic stop_test();
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic idle(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // k busy cycles, the first j of them moving a dword
  task automatic burst(input int k, input int j);
    for (int i = 0; i < k; i++) begin
      @(posedge core_clk);
      mst_rd_busy <= 1'b1;
      mst_dword <= i < j;
    end
    @(posedge core_clk);
    {mst_rd_busy, mst_dword} <= 2'b00;
  endtask : burst
  function automatic logic [1:0] thr_exp(input logic [31:0] v);
    return v[4] ? v[3:2] : 2'h1;
  endfunction : thr_exp
  // ====================
  // scenarios
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    idle(2);
    chk("rx_threshold", 32'h1, 32'(rx_threshold));
    // pause write refused before negotiation completes
    wr(MPF_OFF_CTRL, 32'h0);
    idle(2);
    chk("pause_enable", 32'h1, 32'(pause_enable));
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      {eeprom_load, eeprom_pm} <= {1'b1, i[0]};
      @(posedge core_clk);
      eeprom_load <= 1'b0;
      idle(2);
      chk("cap_ptr", i ? 32'h50 : 32'h0, 32'(cap_ptr));
      chk("new_caps", 32'(i), 32'(new_caps));
    end
    @(posedge core_clk);
    aneg_done <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[18] = 1'b0;
      d[4:2] = i[2:0];
      wr(MPF_OFF_CTRL, d);
      idle(2);
      rd(MPF_OFF_CTRL, r);
      chk("ctrl", (d & 32'h0000007f) | 32'h00080000, r);
      chk("rx_threshold", 32'(thr_exp(d)), 32'(rx_threshold));
      chk("ctrl_outs", 32'({d[6:5], d[1:0]}), 32'({pattern_ptr_reset, pause_enable,
        soft_irq_request, auto_tx_underrun_recover}));
      chk("irq", 32'(d[1]), 32'(irq));
    end
    wr(MPF_OFF_CTRL, 32'h40000);
    idle(2);
    chk("sleep_state", 32'h1, 32'(sleep_state));
    // unicast and multicast ignored while asleep, then the pattern frame wakes
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      wake_frame <= i ? 3'b100 : 3'b011;
      @(posedge core_clk);
      wake_frame <= 3'b000;
      #1 chk("wake_event", 32'(i), 32'(wake_event));
      idle(2);
      chk("sleep_state", 32'(!i), 32'(sleep_state));
    end
    // awake with power management on, a unicast frame wakes too
    @(posedge core_clk);
    wake_frame <= 3'b010;
    @(posedge core_clk);
    wake_frame <= 3'b000;
    #1 chk("wake_event", 32'h1, 32'(wake_event));
    // clearing the wake-lan bit also ends sleep
    wr(MPF_OFF_CTRL, 32'h40000);
    idle(2);
    chk("sleep_state", 32'h1, 32'(sleep_state));
    wr(MPF_OFF_CTRL, 32'h0);
    idle(2);
    chk("sleep_state", 32'h0, 32'(sleep_state));
    chk("irq", 32'h0, 32'(irq));
    wr(MPF_OFF_MASK, 32'h1);
    idle(2);
    chk("irq", 32'h1, 32'(irq));
    rd(MPF_OFF_STAT, r);
    chk("status", 32'h1, r);
    rd(MPF_OFF_STAT, r);
    idle(1);
    chk("status", 32'h0, r);
    chk("irq", 32'h0, 32'(irq));
    rd(MPF_OFF_PERF, r);
    n = 5 + ($random(seed) & 31);
    burst(n, n - 3);
    burst(3, 1);
    rd(MPF_OFF_PERF, r);
    chk("perf", {16'(n + 3), 8'h0, 8'(n - 2)}, r);
    rd(MPF_OFF_PERF, r);
    chk("perf", 32'h0, r);
    rd(4'h2, r);
    chk("unmapped", 32'h0, r);
    // dword count saturates and flags it in status
    burst(260, 260);
    rd(MPF_OFF_PERF, r);
    chk("perf", 32'h010400ff, r);
    rd(MPF_OFF_STAT, r);
    chk("status", 32'h4, r);
    stop_test();
  end
endmodule : tb
